// ===== verilog/lsp_top.sv
/*
  travel limit and sensor positioning logic with an apb register slave.
  assumes switch inputs and command words are sampled through lsp_sync,
  motor_stopped reports standstill, and speed_ref is the live reference.
*/
// Our own choices: register access over APB and the address map.
// Contract
// - request a limit stop while an assigned stop source reads 0
// - after limit stop allow restart only opposite way after standstill
// - both stop sources assigned and at 0 block every restart
// - stop type is ramp, fast or freewheel; freewheel after reset
// - forward stop source: none, command bit, or low-level input
// - reverse stop source offers the same choices as forward
// - stop type writable only when a stop source is assigned
// - sensor edge selectable as rising or falling
// - forward slowdown edge while forward clamps reference to low speed
// - during forward slowdown reverse runs at full speed
// - opposite edge while reverse clears the forward slowdown
// - slowdown state kept in retained storage over power loss
// - disable suppresses slowdown action but edges still tracked
// - mirrored logic both ways; slowdown and stop set separately
// - disable at 1 ignores limit actions and resumes reference
// - a stop assigned to a command bit is active while it reads 0
`timescale 1ns/1ns
`default_nettype none
module lsp_top
  import lsp_pkg::*;
#(
  parameter int NUM_DIN   = `LSP_NUM_DIN,
  parameter int NUM_WORDS = `LSP_NUM_WORDS
) (
  // clock, block reset, retained-store power-on reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    nv_por_n,
  // apb slave
  input  wire lsp_apb_req_t            apb_req,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // switches and fieldbus command words
  input  wire logic [NUM_DIN-1:0]      din,
  input  wire logic [NUM_WORDS*`LSP_WORD_W-1:0] cmd_words,
  // drive side
  input  wire logic                    run_fwd_cmd,
  input  wire logic                    run_rev_cmd,
  input  wire logic                    motor_stopped,
  input  wire logic [`LSP_SPEED_W-1:0] speed_ref,
  output logic      [`LSP_SPEED_W-1:0] ref_out,
  output logic                         fwd_permit,
  output logic                         rev_permit,
  output logic                         stop_req,
  output logic      [1:0]              stop_kind
);
  localparam int NV = NUM_DIN + NUM_WORDS * `LSP_WORD_W;

  lsp_state_t        st;
  lsp_state_t        nx;
  logic [NV-1:0]     lvl;
  logic [NV-1:0]     rise;
  logic [NV-1:0]     fall;
  logic [1:0]        nv_rdata;
  logic              dis_c;
  logic              stop_f_c;
  logic              stop_r_c;
  logic              set_f_c;
  logic              clr_f_c;
  logic              set_r_c;
  logic              clr_r_c;
  logic              ok_f_c;
  logic              ok_r_c;
  logic              clamp_c;
  logic              wr_c;
  logic              rd_setup_c;
  lsp_stop_reg_t     wstop_c;
  lsp_slow_reg_t     wslow_c;
  lsp_status_t       stat_c;

  lsp_sync #(
    .W (NV)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({cmd_words, din}),
    .lvl     (lvl),
    .rise    (rise),
    .fall    (fall)
  );

  lsp_nvmem #(
    .W (2)
  ) u_nv (
    .pclk  (pclk),
    .por_n (nv_por_n),
    .we    (st.restored),
    .wdata ({st.slow_r, st.slow_f}),
    .rdata (nv_rdata)
  );

  function automatic logic src_assigned(input lsp_src_t s);
    return (s.kind == `LSP_SRC_CMD) || (s.kind == `LSP_SRC_DIN);
  endfunction

  // command bits follow the inputs; out-of-range inputs read as 1 (idle)
  // source decode
  function automatic logic src_pick(input lsp_src_t s,
                                    input logic [NV-1:0] v);
    int idx;
    idx = 0;
    if (s.kind == `LSP_SRC_CMD) begin
      idx = NUM_DIN + int'(s.word) * `LSP_WORD_W + int'(s.bit_no);
      return (int'(s.word) < NUM_WORDS) ? v[idx] : 1'b1;
    end
    idx = int'(s.bit_no);
    return (idx < NUM_DIN) ? v[idx] : 1'b1;
  endfunction

  // edges of an unassigned or missing source must never count, since
  // the level pick above reads a missing one as a constant idle 1 and an unassigned one as an input bit
  function automatic logic edge_pick(input lsp_src_t s,
                                     input logic [NV-1:0] v);
    logic ok;
    ok = (s.kind == `LSP_SRC_CMD) ? (int'(s.word) < NUM_WORDS)
                                  : (int'(s.bit_no) < NUM_DIN);
    return src_assigned(s) && ok && src_pick(s, v);
  endfunction

  function automatic logic addr_mapped(input logic [`LSP_ADDR_W-1:0] a);
    return (a == `LSP_ADDR_STOP) || (a == `LSP_ADDR_SLOW) ||
           (a == `LSP_ADDR_SPEED) || (a == `LSP_ADDR_STATUS);
  endfunction

  // zero-wait slave: every access phase completes in its first cycle
  assign pready  = 1'b1;
  assign pslverr = apb_req.psel && apb_req.penable &&
                   !addr_mapped(apb_req.paddr);

  always_comb begin
    nx = st;
    wstop_c = lsp_stop_reg_t'(apb_req.pwdata);
    wslow_c = lsp_slow_reg_t'(apb_req.pwdata);
    wr_c = apb_req.psel && apb_req.penable && apb_req.pwrite;
    rd_setup_c = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

    dis_c = src_assigned(st.slow_cfg.dis_src) &&
            src_pick(st.slow_cfg.dis_src, lvl);

    stop_f_c = src_assigned(st.stop_cfg.src_f) &&
               !src_pick(st.stop_cfg.src_f, lvl) && !dis_c;
    stop_r_c = src_assigned(st.stop_cfg.src_r) &&
               !src_pick(st.stop_cfg.src_r, lvl) && !dis_c;

    set_f_c = st.slow_cfg.edge_rise ? edge_pick(st.slow_cfg.src_f, rise)
                                    : edge_pick(st.slow_cfg.src_f, fall);
    clr_f_c = st.slow_cfg.edge_rise ? edge_pick(st.slow_cfg.src_f, fall)
                                    : edge_pick(st.slow_cfg.src_f, rise);
    set_r_c = st.slow_cfg.edge_rise ? edge_pick(st.slow_cfg.src_r, rise)
                                    : edge_pick(st.slow_cfg.src_r, fall);
    clr_r_c = st.slow_cfg.edge_rise ? edge_pick(st.slow_cfg.src_r, fall)
                                    : edge_pick(st.slow_cfg.src_r, rise);

    ok_f_c = !stop_f_c && (!stop_r_c || motor_stopped) &&
             !(stop_f_c && stop_r_c);
    ok_r_c = !stop_r_c && (!stop_f_c || motor_stopped) &&
             !(stop_f_c && stop_r_c);

    unique case (st.dir)
      LSP_DIR_IDLE: begin
        if (run_fwd_cmd && ok_f_c) begin
          nx.dir = LSP_DIR_FWD;
        end else if (run_rev_cmd && ok_r_c) begin
          nx.dir = LSP_DIR_REV;
        end
      end
      LSP_DIR_FWD: begin
        if (motor_stopped && (!run_fwd_cmd || stop_f_c)) begin
          nx.dir = LSP_DIR_IDLE;
        end
      end
      LSP_DIR_REV: begin
        if (motor_stopped && (!run_rev_cmd || stop_r_c)) begin
          nx.dir = LSP_DIR_IDLE;
        end
      end
      default: begin
        nx.dir = LSP_DIR_IDLE;
      end
    endcase

    // retained state is loaded once after reset release, then tracked
    if (!st.restored) begin
      nx.restored = 1'b1;
      nx.slow_f   = nv_rdata[0];
      nx.slow_r   = nv_rdata[1];
    end else begin
      if (set_f_c && st.dir == LSP_DIR_FWD) begin
        nx.slow_f = 1'b1;
      end else if (clr_f_c && st.dir == LSP_DIR_REV) begin
        nx.slow_f = 1'b0;
      end
      if (set_r_c && st.dir == LSP_DIR_REV) begin
        nx.slow_r = 1'b1;
      end else if (clr_r_c && st.dir == LSP_DIR_FWD) begin
        nx.slow_r = 1'b0;
      end
    end

    // only the running direction is clamped
    clamp_c = !dis_c &&
              ((st.slow_f && st.dir == LSP_DIR_FWD) ||
               (st.slow_r && st.dir == LSP_DIR_REV));
    nx.ref_out = (clamp_c && speed_ref > st.low_speed) ? st.low_speed
                                                       : speed_ref;

    nx.fwd_permit = ok_f_c;
    nx.rev_permit = ok_r_c;
    nx.stop_req = (stop_f_c && st.dir == LSP_DIR_FWD) ||
                  (stop_r_c && st.dir == LSP_DIR_REV) ||
                  (stop_f_c && stop_r_c);

    stat_c = '0;
    stat_c.dir           = st.dir;
    stat_c.motor_stopped = motor_stopped;
    stat_c.disabled      = dis_c;
    stat_c.stop_f        = stop_f_c;
    stat_c.stop_r        = stop_r_c;
    stat_c.slow_f        = st.slow_f;
    stat_c.slow_r        = st.slow_r;
    stat_c.fwd_permit    = st.fwd_permit;
    stat_c.rev_permit    = st.rev_permit;

    // read data captured in the setup cycle, held through access
    if (rd_setup_c) begin
      unique case (apb_req.paddr)
        `LSP_ADDR_STOP:   nx.prdata = 32'(st.stop_cfg);
        `LSP_ADDR_SLOW:   nx.prdata = 32'(st.slow_cfg);
        `LSP_ADDR_SPEED:  nx.prdata = 32'(st.low_speed);
        `LSP_ADDR_STATUS: nx.prdata = 32'(stat_c);
        default:          nx.prdata = 32'h0000_0000;
      endcase
    end

    if (wr_c) begin
      unique case (apb_req.paddr)
        `LSP_ADDR_STOP: begin
          nx.stop_cfg.src_f = wstop_c.src_f;
          nx.stop_cfg.src_r = wstop_c.src_r;
          if ((src_assigned(wstop_c.src_f) ||
               src_assigned(wstop_c.src_r)) &&
              wstop_c.stop_type != `LSP_STOP_BAD) begin
            nx.stop_cfg.stop_type = wstop_c.stop_type;
          end
        end
        `LSP_ADDR_SLOW: begin
          nx.slow_cfg = wslow_c;
          nx.slow_cfg.rsvd = '0;
        end
        `LSP_ADDR_SPEED: begin
          nx.low_speed = apb_req.pwdata[`LSP_SPEED_W-1:0];
        end
        default: begin
          nx.low_speed = st.low_speed;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{dir: LSP_DIR_IDLE,
              stop_cfg: '{rsvd: 14'h0000, stop_type: `LSP_STOP_FREE,
                          src_r: `LSP_SRC_RST, src_f: `LSP_SRC_RST},
              slow_cfg: '{dis_src: `LSP_SRC_RST, rsvd: 7'h00,
                          edge_rise: 1'b0, src_r: `LSP_SRC_RST,
                          src_f: `LSP_SRC_RST},
              low_speed: `LSP_LOW_SPD_RST,
              ref_out: 16'h0000,
              slow_f: 1'b0, slow_r: 1'b0, restored: 1'b0,
              fwd_permit: 1'b0, rev_permit: 1'b0, stop_req: 1'b0,
              prdata: 32'h0000_0000};
    end else begin
      st <= nx;
    end
  end

  assign prdata     = st.prdata;
  assign ref_out    = st.ref_out;
  assign fwd_permit = st.fwd_permit;
  assign rev_permit = st.rev_permit;
  assign stop_req   = st.stop_req;
  assign stop_kind  = st.stop_cfg.stop_type;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_fwd_slow_edge;
    st.restored && set_f_c && st.dir == LSP_DIR_FWD;
  endsequence
  sequence s_fwd_clear_edge;
    st.restored && clr_f_c && !set_f_c && st.dir == LSP_DIR_REV;
  endsequence

  a_stop_at_zero: assert property (
    (stop_f_c && st.dir == LSP_DIR_FWD) |=> stop_req)
    else $error("forward limit open without stop request");
  a_limit_no_same: assert property (
    stop_f_c |=> !fwd_permit)
    else $error("forward run permitted at forward limit");
  a_limit_reverse_ok: assert property (
    (stop_f_c && !stop_r_c && motor_stopped) |=> rev_permit)
    else $error("reverse not permitted after forward limit stop");
  a_both_limits_block: assert property (
    (stop_f_c && stop_r_c) |=> (!fwd_permit && !rev_permit && stop_req))
    else $error("restart allowed with both limits open");
  a_stop_type_legal: assert property (
    stop_kind != `LSP_STOP_BAD)
    else $error("illegal stop type held");
  a_slow_set_edge: assert property (
    s_fwd_slow_edge |=> st.slow_f ##1 st.slow_f || $past(clr_f_c))
    else $error("forward slowdown not set on active edge");
  a_slow_clamp_ref: assert property (
    (st.slow_f && st.dir == LSP_DIR_FWD && !dis_c)
      |=> ref_out <= $past(st.low_speed))
    else $error("reference not clamped in forward slowdown");
  a_reverse_full_speed: assert property (
    (st.dir == LSP_DIR_REV && !st.slow_r) |=> ref_out == $past(speed_ref))
    else $error("reverse clamped by forward slowdown");
  a_slow_clear_edge: assert property (
    s_fwd_clear_edge |=> !st.slow_f)
    else $error("forward slowdown not cleared on opposite edge");
  a_disable_resume: assert property (
    dis_c |=> (ref_out == $past(speed_ref)) && !stop_req)
    else $error("limit action not disabled");
endmodule // lsp_top
`default_nettype wire

// ===== common/lsp_consts.svh
/*
  constants of the limit switch and positioning block: register offsets,
  codes and reset values. assumes inclusion by lsp_pkg and the modules.
*/
`ifndef LSP_CONSTS_SVH
`define LSP_CONSTS_SVH
`define LSP_ADDR_W       8
`define LSP_ADDR_STOP    8'h00
`define LSP_ADDR_SLOW    8'h04
`define LSP_ADDR_SPEED   8'h08
`define LSP_ADDR_STATUS  8'h0C
`define LSP_STOP_RAMP    2'h0
`define LSP_STOP_FAST    2'h1
`define LSP_STOP_FREE    2'h2
`define LSP_STOP_BAD     2'h3
`define LSP_SRC_NONE     2'h0
`define LSP_SRC_CMD      2'h1
`define LSP_SRC_DIN      2'h2
`define LSP_SPEED_W      16
`define LSP_LOW_SPD_RST  16'h0064
`define LSP_NUM_DIN      8
`define LSP_NUM_WORDS    4
`define LSP_WORD_W       16
`define LSP_SRC_RST      8'h00
`endif

// ===== common/lsp_pkg.sv
/*
  types of the limit switch and positioning block.
  assumes lsp_consts.svh is on the include path.
*/
`include "lsp_consts.svh"
package lsp_pkg;
  // source selector: kind, command word, bit or input number
  typedef struct packed {
    logic [1:0] kind;
    logic [1:0] word;
    logic [3:0] bit_no;
  } lsp_src_t;
  typedef enum logic [2:0] {
    LSP_DIR_IDLE = 3'b001,
    LSP_DIR_FWD  = 3'b010,
    LSP_DIR_REV  = 3'b100
  } lsp_dir_t;
  typedef struct packed {
    logic                     psel;
    logic                     penable;
    logic                     pwrite;
    logic [`LSP_ADDR_W-1:0]   paddr;
    logic [31:0]              pwdata;
  } lsp_apb_req_t;
  typedef struct packed {
    logic [13:0] rsvd;
    logic [1:0]  stop_type;
    lsp_src_t    src_r;
    lsp_src_t    src_f;
  } lsp_stop_reg_t;
  typedef struct packed {
    lsp_src_t    dis_src;
    logic [6:0]  rsvd;
    logic        edge_rise;
    lsp_src_t    src_r;
    lsp_src_t    src_f;
  } lsp_slow_reg_t;
  typedef struct packed {
    logic [20:0] rsvd;
    lsp_dir_t    dir;
    logic        motor_stopped;
    logic        disabled;
    logic        stop_f;
    logic        stop_r;
    logic        slow_f;
    logic        slow_r;
    logic        fwd_permit;
    logic        rev_permit;
  } lsp_status_t;
  typedef struct packed {
    lsp_dir_t                 dir;
    lsp_stop_reg_t            stop_cfg;
    lsp_slow_reg_t            slow_cfg;
    logic [`LSP_SPEED_W-1:0]  low_speed;
    logic [`LSP_SPEED_W-1:0]  ref_out;
    logic                     slow_f;
    logic                     slow_r;
    logic                     restored;
    logic                     fwd_permit;
    logic                     rev_permit;
    logic                     stop_req;
    logic [31:0]              prdata;
  } lsp_state_t;
endpackage

// ===== verilog/lsp_sync.sv
/*
  synchroniser and edge detector for a bus of switch and command levels.
  assumes inputs may change at any time relative to pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module lsp_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // raw levels
  input  wire logic [W-1:0] d,
  // synchronised level and edges
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [2:0]   vld_reg;

  // first stage feeds only the second; edges need two settled samples
  // sync before edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      vld_reg <= 3'h0;
    end else begin
      s1_reg  <= d;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      vld_reg <= {vld_reg[1:0], 1'b1};
    end
  end

  assign lvl  = s2_reg;
  assign rise = vld_reg[2] ? (s2_reg & ~s3_reg) : '0;
  assign fall = vld_reg[2] ? (~s2_reg & s3_reg) : '0;

  a_edge_single_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (rise != '0) |=> ((rise & $past(rise)) == '0))
    else $error("edge pulse lasted more than one cycle");
endmodule // lsp_sync
`default_nettype wire

// ===== verilog/lsp_nvmem.sv
/*
  retained store for the slowdown state; only its own power-on reset
  clears it, so the block reset leaves it intact.
  assumes por_n is asserted once when supply first comes up.
*/
`timescale 1ns/1ns
`default_nettype none
module lsp_nvmem #(
  parameter int W = 2
) (
  // clock and power-on reset
  input  wire logic         pclk,
  input  wire logic         por_n,
  // write port
  input  wire logic         we,
  input  wire logic [W-1:0] wdata,
  // registered read port
  output logic      [W-1:0] rdata
);
  logic [W-1:0] mem_reg;

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      mem_reg <= '0;
      rdata   <= '0;
    end else begin
      if (we) begin
        mem_reg <= wdata;
      end
      rdata <= mem_reg;
    end
  end
endmodule // lsp_nvmem
`default_nettype wire

// ===== sim/lsp_drive_model.sv
/*
  far side of the block: switch and command-bit levels set by the bench,
  and a motor that reaches or leaves standstill DLY cycles after the
  drive state changes.
  assumes the bench changes levels on rising edges of pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module lsp_drive_model #(
  parameter int DLY = 4
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // drive commands and block answers
  input  wire logic        run_fwd_cmd,
  input  wire logic        run_rev_cmd,
  input  wire logic        fwd_permit,
  input  wire logic        rev_permit,
  input  wire logic        stop_req,
  // levels wanted by the bench
  input  wire logic [7:0]  din_lvl,
  input  wire logic [63:0] cmd_lvl,
  // switch pins, command words, standstill
  output logic      [7:0]  din,
  output logic      [63:0] cmd_words,
  output logic             motor_stopped
);
  int   cnt;
  logic drive;
  // the motor never answers at once, so standstill lags the permits
  assign drive = !stop_req && ((run_fwd_cmd && fwd_permit) ||
                               (run_rev_cmd && rev_permit));
  assign din       = din_lvl;
  assign cmd_words = cmd_lvl;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt           <= 0;
      motor_stopped <= 1'b1;
    end else if (drive == motor_stopped) begin
      cnt <= cnt + 1;
      if (cnt >= DLY - 1) begin
        motor_stopped <= !drive;
        cnt           <= 0;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule // lsp_drive_model
`default_nettype wire

// ===== sim/lsp_top_bench.sv
/*
  self-checking bench of lsp_top: apb tasks, stop, slowdown, disable
  and retained-state scenarios.
  assumes lsp_drive_model as the far side and the zero-wait apb slave.
*/
`timescale 1ns/1ns
`default_nettype none
`include "lsp_consts.svh"
module lsp_top_bench
  import lsp_pkg::*;
;
  logic         pclk      = 1'b0;
  logic         presetn   = 1'b0;
  logic         nv_por_n  = 1'b0;
  lsp_apb_req_t req       = '0;
  logic [7:0]   din_lvl   = 8'hFF;
  logic [63:0]  cmd_lvl   = 64'hFFFF_FFFF_FFFF_FFFE;
  logic         run_f     = 1'b0;
  logic         run_r     = 1'b0;
  logic [15:0]  spd       = 16'h0200;
  logic [31:0]  prdata;
  logic [31:0]  rd;
  logic         pready;
  logic         pslverr;
  logic         err;
  logic         er;
  logic [7:0]   din;
  logic [63:0]  cmd_words;
  logic         stopped;
  logic [15:0]  ref_out;
  logic         fwd_p;
  logic         rev_p;
  logic         stop_req;
  logic [1:0]   stop_kind;
  int           n_mismatch   = 0;
  int           total_checks = 0;

  always #4 pclk = ~pclk;

  lsp_top #(.NUM_DIN(8), .NUM_WORDS(4)) DUT (
    .pclk(pclk), .presetn(presetn), .nv_por_n(nv_por_n),
    .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .din(din), .cmd_words(cmd_words), .run_fwd_cmd(run_f),
    .run_rev_cmd(run_r), .motor_stopped(stopped), .speed_ref(spd),
    .ref_out(ref_out), .fwd_permit(fwd_p), .rev_permit(rev_p),
    .stop_req(stop_req), .stop_kind(stop_kind));

  lsp_drive_model #(.DLY(4)) u_drive (
    .pclk(pclk), .presetn(presetn), .run_fwd_cmd(run_f),
    .run_rev_cmd(run_r), .fwd_permit(fwd_p), .rev_permit(rev_p),
    .stop_req(stop_req), .din_lvl(din_lvl), .cmd_lvl(cmd_lvl),
    .din(din), .cmd_words(cmd_words), .motor_stopped(stopped));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // request held until the edge at which pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    req <= '0;
  endtask

  initial begin
    wt(20000);
    n_mismatch++;
    stop_test();
  end

  initial begin
    wt(2);
    chk(stop_kind, 2'h2);
    chk({ref_out, fwd_p, rev_p, stop_req}, 19'h0);
    wt(4);
    presetn  <= 1'b1;
    nv_por_n <= 1'b1;
    wt(4);
    apb(1'b0, `LSP_ADDR_STOP, 32'h0);
    chk(rd, 32'h0002_0000);
    apb(1'b0, `LSP_ADDR_SLOW, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `LSP_ADDR_SPEED, 32'h0);
    chk(rd, {16'h0, `LSP_LOW_SPD_RST});
    apb(1'b0, `LSP_ADDR_STATUS, 32'h0);
    chk(rd[10:7], 4'h3);
    apb(1'b0, 8'h10, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    apb(1'b1, `LSP_ADDR_STOP, 32'h0001_0000);
    apb(1'b0, `LSP_ADDR_STOP, 32'h0);
    chk(rd, 32'h0002_0000);
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, `LSP_ADDR_STOP, {14'h0, t[1:0], 16'h0053});
      wt(3);
      chk(stop_kind, (t == 3) ? 2'h2 : t[1:0]);
    end
    // forward stop on command word 1 bit 3
    wt(1);
    run_f <= 1'b1;
    wt(12);
    chk({fwd_p, stop_req, stopped}, 3'b100);
    cmd_lvl[19] <= 1'b0;
    wt(5);
    chk({stop_req, fwd_p, rev_p}, 3'b100);
    wt(12);
    chk({fwd_p, rev_p}, 2'b01);
    run_f <= 1'b0;
    apb(1'b1, `LSP_ADDR_SLOW, 32'h4000_0000);
    cmd_lvl[0] <= 1'b1;
    wt(5);
    chk({stop_req, fwd_p}, 2'b01);
    cmd_lvl[0] <= 1'b0;
    apb(1'b1, `LSP_ADDR_SLOW, 32'h0);
    wt(1);
    run_r <= 1'b1;
    wt(12);
    apb(1'b0, `LSP_ADDR_STATUS, 32'h0);
    chk(rd[10:8], 3'b100);
    run_r <= 1'b0;
    wt(12);
    apb(1'b1, `LSP_ADDR_STOP, 32'h0002_8053);
    din_lvl[0] <= 1'b0;
    wt(5);
    chk({fwd_p, rev_p}, 2'b00);
    din_lvl[0]  <= 1'b1;
    cmd_lvl[19] <= 1'b1;
    apb(1'b1, `LSP_ADDR_STOP, 32'h0);
    apb(1'b1, `LSP_ADDR_SPEED, 32'h0010);
    // slowdown on input 1, rising then falling edge active
    for (int i = 0; i < 2; i++) begin
      er = (i == 0);
      din_lvl[1] <= ~er;
      apb(1'b1, `LSP_ADDR_SLOW, {15'h0, er, 16'h0081});
      wt(1);
      run_f <= 1'b1;
      wt(12);
      din_lvl[1] <= er;
      wt(5);
      chk(ref_out, 16'h0010);
      apb(1'b0, `LSP_ADDR_STATUS, 32'h0);
      chk(rd[3], 1'b1);
      run_f <= 1'b0;
      wt(12);
      run_r <= 1'b1;
      wt(12);
      chk(ref_out, spd);
      din_lvl[1] <= ~er;
      wt(5);
      apb(1'b0, `LSP_ADDR_STATUS, 32'h0);
      chk(rd[3], 1'b0);
      run_r <= 1'b0;
      wt(12);
    end
    // reverse slowdown on input 2, falling edge active
    apb(1'b1, `LSP_ADDR_SLOW, 32'h0000_8200);
    run_r <= 1'b1;
    wt(12);
    din_lvl[2] <= 1'b0;
    wt(5);
    chk(ref_out, 16'h0010);
    run_r <= 1'b0;
    wt(12);
    din_lvl[2] <= 1'b1;
    // disabled slowdown still records the edge
    apb(1'b1, `LSP_ADDR_SLOW, 32'h4000_0081);
    cmd_lvl[0] <= 1'b1;
    wt(1);
    run_f <= 1'b1;
    wt(12);
    din_lvl[1] <= 1'b0;
    wt(5);
    chk(ref_out, spd);
    apb(1'b0, `LSP_ADDR_STATUS, 32'h0);
    chk({rd[6], rd[3]}, 2'b11);
    cmd_lvl[0] <= 1'b0;
    wt(5);
    chk(ref_out, 16'h0010);
    run_f <= 1'b0;
    wt(12);
    presetn <= 1'b0;
    wt(2);
    presetn <= 1'b1;
    wt(4);
    apb(1'b0, `LSP_ADDR_STATUS, 32'h0);
    chk(rd[3], 1'b1);
    presetn  <= 1'b0;
    nv_por_n <= 1'b0;
    wt(2);
    presetn  <= 1'b1;
    nv_por_n <= 1'b1;
    wt(4);
    apb(1'b0, `LSP_ADDR_STATUS, 32'h0);
    chk(rd[3], 1'b0);
    stop_test();
  end
endmodule // lsp_top_bench
`default_nettype wire
